// >>> pkg/orp_pkg.sv
// Package of constants and types for the one-time-programmable memory programmer
//
// Overview of operation
// - Each program pulse drives chip enable low for nominally 100 us with program voltage on.
// - Start at address zero, raise supply to 6.5V and program pin to 13.0V.
// - First pass gives every address exactly one pulse, with no verify read.
// - A separate verify and reprogram loop then visits every address in turn.
// - A failing byte gets up to 10 more pulses, verified after each one.
// - Still failing after 10 extra pulses: stop and flag the whole part failed.
// - A verified byte advances the address until every address has been checked.
// - Then program pin low, supply to 5.0V, read and compare bytes until the first mismatch or the last address, decide pass.
// - Identification: chip and output enable low, high voltage line raised, A0 selects maker or type byte, other address lines low.
package orp_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_MHZ = 50;
  localparam int PULSE_WIDTH_US = 100;
  localparam int PULSE_CYCLES = PULSE_WIDTH_US * CLK_MHZ;
  localparam int SETUP_US = 2;
  localparam int SETUP_CYCLES = SETUP_US * CLK_MHZ;
  localparam int DATA_VALID_US = 1;
  localparam int DATA_VALID_CYCLES = DATA_VALID_US * CLK_MHZ;

  // ==========================================================================
  // Algorithm limits and array shape
  localparam int RETRY_LIMIT = 10;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ID_LINE_BIT = 9;

  // ==========================================================================
  // Supply selection codes for the external regulators
  localparam logic [1:0] VCC_READ = 2'h0;
  localparam logic [1:0] VCC_PROG = 2'h1;
  localparam logic [1:0] VCC_VERIFY = 2'h2;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ORP_IDLE, ORP_RAMP, ORP_P1_SET, ORP_P1_PULSE, ORP_V_SET, ORP_V_READ,
    ORP_V_PULSE, ORP_F_SET, ORP_F_READ, ORP_ID_SET, ORP_ID_READ, ORP_DONE
  } orp_state_t;

endpackage

// >>> pkg/orp_src_if.sv
// Interface carrying source data lookups between sequencer and source port
`timescale 1ns/100ps
interface orp_src_if;
  logic [15:0] addr;
  logic [7:0] data;
  modport seq (output addr, input data);
  modport port (input addr, output data);
endinterface

// >>> hw/orp_src_port.sv
// Registered source data fetch from the user image
`timescale 1ns/100ps
module orp_src_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // User image
  output logic [15:0] img_addr_o,
  input wire logic [7:0] img_data_i,
  // Sequencer side
  orp_src_if.port src
);
  // Image answers combinationally; data is held one cycle for timing
  assign img_addr_o = src.addr;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      src.data <= 8'h00;
    end else begin
      src.data <= img_data_i;
    end
  end
endmodule

// >>> hw/orp_programmer.sv
// Programming, verify and identification sequencer for the byte-wide memory
`timescale 1ns/100ps
module orp_programmer #(
  parameter int PULSE_CYC = orp_pkg::PULSE_CYCLES,
  parameter int LAST_ADDR = 16'hFFFF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command
  input wire logic start_prog_i,
  input wire logic start_id_i,
  output logic busy_o,
  output logic done_o,
  output logic pass_o,
  output logic fail_o,
  output logic [7:0] maker_id_o,
  output logic [7:0] type_id_o,
  // Source image
  output logic [15:0] img_addr_o,
  input wire logic [7:0] img_data_i,
  // Memory pins
  output logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_data_i,
  output logic [7:0] mem_data_o,
  output logic mem_data_oe_n_o,
  output logic mem_ce_n_o,
  output logic mem_oe_n_o,
  output logic vpp_on_o,
  output logic id_mode_high_voltage_line_o,
  output logic [1:0] vcc_sel_o
);
  orp_src_if src ();
  orp_pkg::orp_state_t state, next_state;
  logic [15:0] addr;
  logic [31:0] cnt;
  logic [3:0] retries;
  logic id_byte_select;
  logic fail_flag;
  logic [7:0] maker, dtype;

  orp_src_port u_src (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .img_addr_o(img_addr_o),
    .img_data_i(img_data_i),
    .src(src)
  );

  // ==========================================================================
  // Decode
  function automatic logic timer_hit(input logic [31:0] c, input int lim);
    timer_hit = (c >= 32'(lim - 1));
  endfunction

  wire last_addr = (addr == 16'(LAST_ADDR));
  wire setup_ok = timer_hit(cnt, orp_pkg::SETUP_CYCLES);
  wire pulse_ok = timer_hit(cnt, PULSE_CYC);
  wire retry_ok = timer_hit(cnt, orp_pkg::SETUP_CYCLES + PULSE_CYC);
  wire read_ok = timer_hit(cnt, orp_pkg::DATA_VALID_CYCLES);
  wire match = (mem_data_i == src.data);
  wire retry_left = (retries < 4'(orp_pkg::RETRY_LIMIT));
  wire in_pulse = (state == orp_pkg::ORP_P1_PULSE) || (state == orp_pkg::ORP_V_PULSE);
  // Retry pulse waits out a setup span first, so chip enable never runs on from the verify read
  wire ce_pulse = (state == orp_pkg::ORP_P1_PULSE) ||
                  ((state == orp_pkg::ORP_V_PULSE) && (cnt >= 32'(orp_pkg::SETUP_CYCLES)));
  wire in_read = (state == orp_pkg::ORP_V_READ) || (state == orp_pkg::ORP_F_READ) ||
                 (state == orp_pkg::ORP_ID_READ);
  wire prog_phase = (state == orp_pkg::ORP_RAMP) || (state == orp_pkg::ORP_P1_SET) || in_pulse ||
                    (state == orp_pkg::ORP_V_SET) || (state == orp_pkg::ORP_V_READ);
  wire id_phase = (state == orp_pkg::ORP_ID_SET) || (state == orp_pkg::ORP_ID_READ);

  // ==========================================================================
  // Next state
  always_comb begin
    next_state = state;
    case (state)
      orp_pkg::ORP_IDLE: begin
        if (start_prog_i) begin
          next_state = orp_pkg::ORP_RAMP;
        end else if (start_id_i) begin
          next_state = orp_pkg::ORP_ID_SET;
        end
      end
      orp_pkg::ORP_RAMP: if (setup_ok) next_state = orp_pkg::ORP_P1_SET;
      orp_pkg::ORP_P1_SET: if (setup_ok) next_state = orp_pkg::ORP_P1_PULSE;
      orp_pkg::ORP_P1_PULSE: begin
        if (pulse_ok) begin
          next_state = last_addr ? orp_pkg::ORP_V_SET : orp_pkg::ORP_P1_SET;
        end
      end
      orp_pkg::ORP_V_SET: if (setup_ok) next_state = orp_pkg::ORP_V_READ;
      orp_pkg::ORP_V_READ: begin
        if (read_ok) begin
          if (match) begin
            next_state = last_addr ? orp_pkg::ORP_F_SET : orp_pkg::ORP_V_SET;
          end else if (retry_left) begin
            next_state = orp_pkg::ORP_V_PULSE;
          end else begin
            next_state = orp_pkg::ORP_DONE;
          end
        end
      end
      orp_pkg::ORP_V_PULSE: if (retry_ok) next_state = orp_pkg::ORP_V_SET;
      orp_pkg::ORP_F_SET: if (setup_ok) next_state = orp_pkg::ORP_F_READ;
      orp_pkg::ORP_F_READ: begin
        if (read_ok) begin
          if (!match || last_addr) begin
            next_state = orp_pkg::ORP_DONE;
          end else begin
            next_state = orp_pkg::ORP_F_SET;
          end
        end
      end
      orp_pkg::ORP_ID_SET: if (setup_ok) next_state = orp_pkg::ORP_ID_READ;
      orp_pkg::ORP_ID_READ: begin
        if (read_ok) begin
          next_state = id_byte_select ? orp_pkg::ORP_DONE : orp_pkg::ORP_ID_SET;
        end
      end
      orp_pkg::ORP_DONE: next_state = orp_pkg::ORP_IDLE;
      default: next_state = orp_pkg::ORP_IDLE;
    endcase
  end

  // ==========================================================================
  // Sequencer registers
  wire leaving = (next_state != state);
  wire verify_adv = (state == orp_pkg::ORP_V_READ) && read_ok && match;
  wire step_adv = ((state == orp_pkg::ORP_P1_PULSE) && pulse_ok) || verify_adv ||
                  ((state == orp_pkg::ORP_F_READ) && read_ok && match);
  wire fail_now = ((state == orp_pkg::ORP_V_READ) && read_ok && !match && !retry_left) ||
                  ((state == orp_pkg::ORP_F_READ) && read_ok && !match);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= orp_pkg::ORP_IDLE;
      cnt <= 32'h0000_0000;
    end else begin
      state <= next_state;
      cnt <= leaving ? 32'h0000_0000 : cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr <= 16'h0000;
      retries <= 4'h0;
    end else if (state == orp_pkg::ORP_IDLE || (step_adv && last_addr)) begin
      addr <= 16'h0000;
      retries <= 4'h0;
    end else if (step_adv) begin
      addr <= addr + 16'h0001;
      retries <= 4'h0;
    end else if (state == orp_pkg::ORP_V_READ && read_ok && !match && retry_left) begin
      retries <= retries + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      id_byte_select <= 1'b0;
      maker <= 8'h00;
      dtype <= 8'h00;
      fail_flag <= 1'b0;
    end else begin
      if (state == orp_pkg::ORP_IDLE) begin
        id_byte_select <= 1'b0;
        fail_flag <= 1'b0;
      end else if (state == orp_pkg::ORP_ID_READ && read_ok) begin
        id_byte_select <= 1'b1;
        if (id_byte_select) dtype <= mem_data_i;
        else maker <= mem_data_i;
      end
      if (fail_now) fail_flag <= 1'b1;
    end
  end

  // ==========================================================================
  // Pins and status
  assign src.addr = addr;
  assign mem_addr_o = id_phase ? {6'h00, 1'b0, 9'(id_byte_select)} : addr;
  assign id_mode_high_voltage_line_o = id_phase;
  assign mem_ce_n_o = !(ce_pulse || in_read);
  assign vpp_on_o = prog_phase && !(state == orp_pkg::ORP_V_READ);
  assign mem_oe_n_o = !in_read;
  assign mem_data_o = src.data;
  assign mem_data_oe_n_o = !(prog_phase && !in_read); // Never drive while the part drives
  assign vcc_sel_o = prog_phase || id_phase ? orp_pkg::VCC_PROG :
                     (state == orp_pkg::ORP_F_SET || state == orp_pkg::ORP_F_READ) ?
                     orp_pkg::VCC_VERIFY : orp_pkg::VCC_READ;
  assign busy_o = (state != orp_pkg::ORP_IDLE);
  assign done_o = (state == orp_pkg::ORP_DONE);
  assign pass_o = done_o && !fail_flag && !id_byte_select;
  assign fail_o = fail_flag;
  assign maker_id_o = maker;
  assign type_id_o = dtype;
endmodule

// >>> tb/orp_programmer_assertions.sv
// Port checker for the memory programmer
`timescale 1ns/100ps
module orp_programmer_assertions #(
  parameter int PULSE_CYC = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Status
  input wire logic done_o,
  input wire logic pass_o,
  // Memory pins
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_data_oe_n_o,
  input wire logic mem_ce_n_o,
  input wire logic mem_oe_n_o,
  input wire logic vpp_on_o,
  input wire logic id_mode_high_voltage_line_o,
  input wire logic [1:0] vcc_sel_o
);
  // ==========================
  // Helper: length of the current low stretch on chip enable
  int low_cnt;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= mem_ce_n_o ? 0 : low_cnt + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================
  // Properties
  property p_pulse_len;
    $rose(mem_ce_n_o) && $past(vpp_on_o) |-> $past(low_cnt) == PULSE_CYC - 1;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("program pulse length wrong");
  property p_pulse_drive;
    !mem_ce_n_o && mem_oe_n_o |-> vpp_on_o && !mem_data_oe_n_o;
  endproperty
  a_pulse_drive: assert property (p_pulse_drive) else $error("pulse without vpp or data");
  property p_prog_vcc;
    vpp_on_o |-> vcc_sel_o == 2'h1;
  endproperty
  a_prog_vcc: assert property (p_prog_vcc) else $error("vpp on without program supply");
  property p_read_quiet;
    !mem_oe_n_o |-> !vpp_on_o && mem_data_oe_n_o && !mem_ce_n_o;
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read with vpp or data driven");
  property p_id_addr;
    id_mode_high_voltage_line_o |-> mem_addr_o[15:1] == 15'h0000;
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("id mode address lines not low");
  property p_final_vpp;
    vcc_sel_o == 2'h2 |-> !vpp_on_o && !id_mode_high_voltage_line_o;
  endproperty
  a_final_vpp: assert property (p_final_vpp) else $error("final check with high voltage");
  property p_pass_done;
    pass_o |-> done_o;
  endproperty
  a_pass_done: assert property (p_pass_done) else $error("pass without done");
  property p_done_one;
    done_o |=> !done_o;
  endproperty
  a_done_one: assert property (p_done_one) else $error("done longer than one cycle");
endmodule
bind orp_programmer orp_programmer_assertions #(.PULSE_CYC(PULSE_CYC)) u_orp_programmer_assertions (.clk_i,
  .rst_i, .done_o, .pass_o, .mem_addr_o, .mem_data_oe_n_o, .mem_ce_n_o, .mem_oe_n_o, .vpp_on_o,
  .id_mode_high_voltage_line_o, .vcc_sel_o);

// >>> tb/orp_otp_model.sv
// Behavioural model of the byte-wide one-time-programmable memory
`timescale 1ns/100ps
module orp_otp_model #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] TYPE_ID = 8'hC3 // Arbitrary value
) (
  // Bench control
  input wire logic clear_i,
  input wire logic [1:0] weak_addr_i,
  input wire logic [7:0] weak_pulses_i,
  // Memory pins
  input wire logic [15:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic vpp_on_i,
  input wire logic id_line_i,
  output logic [7:0] data_o
);
  logic [7:0] cells [4];
  logic [7:0] hits [4];
  logic [7:0] last;
  logic [1:0] pa;
  logic [7:0] pd;
  logic pw = 1'b0;
  wire logic [1:0] a = addr_i[1:0];
  wire logic rd_en = !ce_n_i && !oe_n_i;
  wire logic id_en = id_line_i && addr_i[15:1] == 15'h0000;
  wire logic [7:0] rd = id_en ? (addr_i[0] ? TYPE_ID : MAKER_ID) : cells[a];
  always @(posedge clear_i) begin
    cells = '{default: 8'hFF};
    hits = '{default: 8'h00};
  end
  // Pins are latched once settled after chip enable falls; address may move as it rises
  always @(negedge ce_n_i) begin
    #1;
    pa = a;
    pd = data_i;
    pw = vpp_on_i && oe_n_i;
  end
  // Weak cell takes the byte only after enough pulses
  always @(posedge ce_n_i) begin
    if (pw) begin
      hits[pa] = hits[pa] + 8'h01;
      if (pa != weak_addr_i || hits[pa] >= weak_pulses_i) begin
        cells[pa] = cells[pa] & pd;
      end
    end
    pw = 1'b0;
  end
  always @(rd or rd_en) begin
    if (rd_en) begin
      last = rd;
    end
  end
  // Released bus shows the inverse so stale data never passes
  assign data_o = rd_en ? rd : ~last;
endmodule

// >>> tb/tb_otp_rom_program_verify.sv
// Testbench for the memory programmer against the device model
`timescale 1ns/100ps
module tb_otp_rom_program_verify;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_prog_i = 1'b0;
  logic start_id_i = 1'b0;
  logic clear = 1'b0;
  logic [1:0] weak_addr = 2'h0;
  logic [7:0] weak_pulses = 8'h01;
  logic busy_o, done_o, pass_o, fail_o, mem_data_oe_n_o, mem_ce_n_o, mem_oe_n_o, vpp_on_o;
  logic id_mode_high_voltage_line_o;
  logic [7:0] maker_id_o, type_id_o, mem_data_i, mem_data_o;
  logic [15:0] img_addr_o, mem_addr_o;
  logic [1:0] vcc_sel_o;
  logic [7:0] img [4] = '{8'h3C, 8'hA5, 8'h00, 8'h7E};
  wire logic [7:0] img_data_i = img[img_addr_o[1:0]];
  int failures = 0;
  int check_count = 0;
  int pulses = 0;
  int reads = 0;
  orp_programmer #(.PULSE_CYC(20), .LAST_ADDR(16'h0003)) u_orp_programmer (.clk_i, .rst_i, .start_prog_i,
    .start_id_i, .busy_o, .done_o, .pass_o, .fail_o, .maker_id_o, .type_id_o, .img_addr_o, .img_data_i,
    .mem_addr_o, .mem_data_i, .mem_data_o, .mem_data_oe_n_o, .mem_ce_n_o, .mem_oe_n_o, .vpp_on_o,
    .id_mode_high_voltage_line_o, .vcc_sel_o);
  orp_otp_model #(.MAKER_ID(8'h5A), .TYPE_ID(8'hC3)) u_orp_otp_model (.clear_i(clear),
    .weak_addr_i(weak_addr), .weak_pulses_i(weak_pulses), .addr_i(mem_addr_o), .data_i(mem_data_o),
    .ce_n_i(mem_ce_n_o), .oe_n_i(mem_oe_n_o), .vpp_on_i(vpp_on_o), .id_line_i(id_mode_high_voltage_line_o),
    .data_o(mem_data_i));
  initial forever #10 clk_i = ~clk_i;
  // Count at the settled falling edge; vpp and chip enable move together when a read starts
  always @(negedge mem_ce_n_o) begin
    #1;
    if (vpp_on_o === 1'b1 && mem_oe_n_o === 1'b1) pulses++;
  end
  always @(negedge mem_oe_n_o) reads++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait so a stuck sequencer cannot hang the run
  task automatic go(input logic prog, input logic [1:0] wa, input logic [7:0] wp);
    clear <= 1'b1;
    weak_addr <= wa;
    weak_pulses <= wp;
    pulses = 0;
    reads = 0;
    @(posedge clk_i);
    clear <= 1'b0;
    start_prog_i <= prog;
    start_id_i <= !prog;
    @(posedge clk_i);
    start_prog_i <= 1'b0;
    start_id_i <= 1'b0;
    repeat (8000) begin
      @(posedge clk_i);
      #1;
      if (done_o === 1'b1) break;
    end
    chk({15'h0000, done_o}, 16'h0001);
    chk({15'h0000, busy_o}, 16'h0001);
  endtask
  task automatic t_clean;
    go(1'b1, 2'h0, 8'h01);
    chk({15'h0000, pass_o}, 16'h0001);
    chk(pulses[15:0], 16'h0004);
    chk(reads[15:0], 16'h0008);
  endtask
  task automatic t_retry;
    go(1'b1, 2'h2, 8'h06);
    chk({15'h0000, pass_o}, 16'h0001);
    chk(pulses[15:0], 16'h0009);
    chk(reads[15:0], 16'h000D);
  endtask
  task automatic t_fail;
    go(1'b1, 2'h1, 8'h14);
    chk({14'h0000, fail_o, pass_o}, 16'h0002);
    chk(pulses[15:0], 16'h000E);
    chk(reads[15:0], 16'h000C);
  endtask
  task automatic t_ident;
    go(1'b0, 2'h0, 8'h01);
    chk({maker_id_o, type_id_o}, 16'h5AC3);
    chk(reads[15:0], 16'h0002);
    chk(pulses[15:0], 16'h0000);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_clean();
    t_retry();
    t_fail();
    t_ident();
    tally_and_finish();
  end
endmodule
